/* File: verilog/usr_pkg.sv */
// package: register map, field positions, reset values and states of the serial port
package usr_pkg;
    // register offsets
    localparam logic [2:0] ADR_DATA = 3'h0; // data register (tx buffer / rx buffer)
    localparam logic [2:0] ADR_CSA = 3'h1; // ctrl_status_a
    localparam logic [2:0] ADR_CSB = 3'h2; // ctrl_status_b
    localparam logic [2:0] ADR_CSC = 3'h3; // ctrl_status_c
    localparam logic [2:0] ADR_BRL = 3'h4; // baud_divisor low byte
    localparam logic [2:0] ADR_BRH = 3'h5; // baud_divisor high nibble
    // ctrl_status_a fields
    localparam int A_RXC = 7; // rx_complete_flag, read only
    localparam int A_TXC = 6; // tx_complete_flag, write one to clear
    localparam int A_TX_BUFFER_EMPTY_FLAG = 5; // tx_buffer_empty_flag, read only
    localparam int A_U2X = 1; // double_speed_bit
    // ctrl_status_b fields
    localparam int B_RXCIE = 7; // rx complete irq enable
    localparam int B_TX_COMPLETE_IRQ_ENABLE = 6; // tx_complete_irq_enable
    localparam int B_TX_EMPTY_IRQ_ENABLE = 5; // tx_empty_irq_enable
    localparam int B_RX_ENABLE_BIT = 4; // rx_enable_bit
    localparam int B_TX_ENABLE_BIT = 3; // tx_enable_bit
    localparam int B_CSZ2 = 2; // char_size_field bit 2
    localparam int B_RX_NINTH_BIT = 1; // rx_ninth_bit, read only
    localparam int B_TX_NINTH_BIT = 0; // tx_ninth_bit
    // ctrl_status_c fields
    localparam int C_SYNC = 6; // synchronous mode
    localparam int C_PM1 = 5; // parity_mode_field bit 1: parity on
    localparam int C_PM0 = 4; // parity_mode_field bit 0: odd parity
    localparam int C_STOP2 = 3; // two stop bits
    localparam int C_CSZ1 = 2; // char_size_field bit 1
    localparam int C_CSZ0 = 1; // char_size_field bit 0
    localparam int C_POL = 0; // clock polarity in synchronous mode
    // reset values
    localparam logic [7:0] RST_CSB = 8'h00;
    localparam logic [7:0] RST_CSC = 8'h06; // eight data bits
    localparam logic [11:0] RST_BAUD = 12'h000;
    // frame constants
    localparam logic [2:0] CSZ_NINE = 3'h7; // nine bit character code
    localparam logic [3:0] CSZ_BASE = 4'h5; // data bits for code 0
    localparam logic [4:0] OSR_NORM = 5'h10; // 16 samples per bit
    localparam logic [4:0] OSR_DBL = 5'h08; // 8 samples per bit
    // state machines
    typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} usr_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10} usr_rx_st_t;
endpackage

/* File: verilog/usr_datapath.sv */
// module: transmit and receive data paths of the serial port with register port
// Overview of operation
// - tx enable drives serial output pin
// - sync mode clocks transmit from clock pin
// - data write fills buffer, moves when idle
// - shift register sends frame at bit rate
// - unused upper data bits ignored on transmit
// - empty flag high exactly when buffer empty
// - empty irq follows flag; write clears flag
// - complete flag when frame out, buffer empty
// - complete flag cleared by service or one
// - complete irq raised while flag and enable
// - parity bit placed after last data bit
// - tx disable waits for shifter and buffer
// - rx enable takes over serial input pin
// - sync mode samples receive on clock pin
// - start bit begins reception, bits shifted in
// - second stop bit ignored by receiver
// - first stop bit moves frame to buffer
// - upper unused read bits return zero
// - divide by 16, or 8 at double speed
// - start, data lsb first, parity, stops, idle high
// - parity is xor of data, inverted odd
// - ninth received bit held in status bit
//
// Design decisions made here: the address map and strobed register access.
module usr_datapath
    import usr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    output logic serial_out_pin,
    output logic serial_out_oe,
    input wire logic serial_in_pin,
    output logic serial_in_override,
    input wire logic serial_clock_pin,
    output logic serial_clock_override,
    output logic tx_empty_irq,
    output logic tx_complete_irq,
    input wire logic tx_complete_irq_ack,
    output logic rx_complete_irq
);
    import usr_pkg::*;

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [7:0] csb_r; // ctrl_status_b writable bits
    logic [7:0] csc_r; // ctrl_status_c
    logic [11:0] baud_r; // baud_divisor
    logic u2x_r; // double_speed_bit
    logic [7:0] rdata_r; // read data, one cycle after strobe
    logic wr_data, wr_csa; // decoded writes
    logic rd_data; // decoded data read

    assign wr_data = wr_stb && (addr == ADR_DATA);
    assign wr_csa = wr_stb && (addr == ADR_CSA);
    assign rd_data = rd_stb && (addr == ADR_DATA);

    // configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            csb_r <= RST_CSB;
            csc_r <= RST_CSC;
            baud_r <= RST_BAUD;
            u2x_r <= 1'b0;
        end else if (wr_stb) begin
            unique case (addr)
                ADR_CSA: u2x_r <= wdata[A_U2X];
                ADR_CSB: csb_r <= wdata;
                ADR_CSC: csc_r <= wdata;
                ADR_BRL: baud_r[7:0] <= wdata;
                ADR_BRH: baud_r[11:8] <= wdata[3:0];
                default: ; // data register and unmapped
            endcase
        end
    end

    // ----------------------------------------
    // frame format decode
    // ----------------------------------------
    logic [2:0] csz; // char_size_field
    logic [3:0] nbits; // data bits per character
    logic [8:0] dmask; // mask of valid data bits
    logic sync_md, par_en, par_odd, stop2, pol;
    logic [4:0] osr; // samples per bit

    assign csz = {csb_r[B_CSZ2], csc_r[C_CSZ1], csc_r[C_CSZ0]};
    assign nbits = (csz == CSZ_NINE) ? 4'd9 : (CSZ_BASE + {2'b00, csz[1:0]});
    assign sync_md = csc_r[C_SYNC];
    assign par_en = csc_r[C_PM1];
    assign par_odd = csc_r[C_PM0];
    assign stop2 = csc_r[C_STOP2];
    assign pol = csc_r[C_POL];
    assign osr = u2x_r ? OSR_DBL : OSR_NORM;

    // valid data bit mask
    always_comb begin
        dmask = 9'h000;
        for (int i = 0; i < 9; i++) begin
            dmask[i] = (4'(i) < nbits);
        end
    end

    // ----------------------------------------
    // pin synchronisers and clock edges
    // ----------------------------------------
    logic [1:0] rxd_s, sck_s; // two stage synchronisers
    logic sck_d; // previous synchronised clock
    logic rxd; // synchronised serial input
    logic sck_rise, sck_fall, tx_edge, rx_edge;

    // synchronise serial input and clock pin
    always_ff @(posedge clk) begin
        if (rst) begin
            rxd_s <= 2'b11;
            sck_s <= 2'b00;
            sck_d <= 1'b0;
        end else begin
            rxd_s <= {rxd_s[0], serial_in_pin};
            sck_s <= {sck_s[0], serial_clock_pin};
            sck_d <= sck_s[1];
        end
    end

    assign rxd = rxd_s[1];
    assign sck_rise = sck_s[1] && !sck_d;
    assign sck_fall = !sck_s[1] && sck_d;
    assign tx_edge = pol ? sck_fall : sck_rise;
    assign rx_edge = pol ? sck_rise : sck_fall;

    // ----------------------------------------
    // baud divider: one tick per sample slot
    // ----------------------------------------
    logic [11:0] brc_r; // down counter
    logic btick; // sample tick

    assign btick = (brc_r == 12'h000);

    // reload from divisor at every tick
    always_ff @(posedge clk) begin
        if (rst) begin
            brc_r <= RST_BAUD;
        end else if (btick) begin
            brc_r <= baud_r;
        end else begin
            brc_r <= brc_r - 12'h001;
        end
    end

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    usr_tx_st_t tx_st_r; // transmit state
    logic [8:0] tbuf_r; // transmit buffer
    logic tfull_r; // buffer holds unsent data
    logic [12:0] tsh_r; // shift register, lsb goes out first
    logic [3:0] tcnt_r; // bits left in frame
    logic [4:0] tos_r; // sample counter within bit
    logic txc_r; // tx_complete_flag
    logic tx_act; // transmitter owns the pin
    logic tbit; // bit period over
    logic tload; // move buffer to shifter
    logic tlast; // last stop bit finishing
    logic [12:0] tframe; // assembled frame
    logic [3:0] tlen; // frame length in bits

    // frame build: start, data lsb first, parity, stops
    always_comb begin
        logic [8:0] d;
        d = tbuf_r & dmask;
        tframe = 13'h1fff;
        tframe[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (dmask[i]) begin
                tframe[i + 1] = d[i];
            end
        end
        if (par_en) begin
            tframe[nbits + 4'd1] = (^d) ^ par_odd;
        end
        tlen = 4'd2 + nbits + {3'b000, par_en} + {3'b000, stop2};
    end

    // disable held off until shifter and buffer empty
    assign tx_act = csb_r[B_TX_ENABLE_BIT] || tfull_r || (tx_st_r == TX_SEND);
    assign tbit = sync_md ? tx_edge : (btick && (tos_r == osr - 5'd1));
    assign tlast = (tx_st_r == TX_SEND) && tbit && (tcnt_r == 4'd1);
    // sync mode: an idle shifter loads only on a change edge, so the start bit lines up with the clock pin
    assign tload = tfull_r && tx_act && (((tx_st_r == TX_IDLE) && (!sync_md || tx_edge)) || tlast);

    // buffer fill by cpu write, drain by shifter load
    always_ff @(posedge clk) begin
        if (rst) begin
            tbuf_r <= 9'h000;
            tfull_r <= 1'b0;
        end else if (wr_data) begin
            tbuf_r <= {csb_r[B_TX_NINTH_BIT], wdata};
            tfull_r <= 1'b1;
        end else if (tload) begin
            tfull_r <= 1'b0;
        end
    end

    // shift register and frame sequencing
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_st_r <= TX_IDLE;
            tsh_r <= 13'h1fff;
            tcnt_r <= 4'h0;
            tos_r <= 5'h00;
        end else if (tload) begin
            tx_st_r <= TX_SEND;
            tsh_r <= tframe;
            tcnt_r <= tlen;
            tos_r <= 5'h00;
        end else if (tx_st_r == TX_SEND) begin
            if (btick) begin
                tos_r <= (tos_r == osr - 5'd1) ? 5'h00 : tos_r + 5'd1;
            end
            if (tbit) begin
                tsh_r <= {1'b1, tsh_r[12:1]};
                tcnt_r <= tcnt_r - 4'd1;
                if (tlast) begin
                    tx_st_r <= TX_IDLE;
                end
            end
        end
    end

    // transmit complete flag, set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            txc_r <= 1'b0;
        end else if (tlast && !tfull_r) begin
            txc_r <= 1'b1;
        end else if (tx_complete_irq_ack || (wr_csa && wdata[A_TXC])) begin
            txc_r <= 1'b0;
        end
    end

    // pin drive: frame bits while sending, else idle high
    assign serial_out_oe = tx_act;
    assign serial_out_pin = (tx_st_r == TX_SEND) ? tsh_r[0] : 1'b1;
    assign serial_clock_override = sync_md && (tx_act || csb_r[B_RX_ENABLE_BIT]);

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    usr_rx_st_t rx_st_r; // receive state
    logic [9:0] rsh_r; // receive shift register
    logic [3:0] rbit_r; // bits taken after start
    logic [4:0] ros_r; // sample counter within bit
    logic [8:0] rbuf_r; // receive buffer
    logic rxc_r; // rx complete flag
    logic rsamp; // sample point of a bit
    logic [3:0] rneed; // bits up to first stop
    logic rdone; // first stop bit sampled

    // first stop bit ends the frame
    assign rneed = nbits + {3'b000, par_en} + 4'd1;
    assign rsamp = sync_md ? rx_edge : (btick && (ros_r == osr - 5'd1));
    assign rdone = (rx_st_r == RX_DATA) && rsamp && (rbit_r == rneed - 4'd1);
    assign serial_in_override = csb_r[B_RX_ENABLE_BIT];

    // start detection and bit sampling
    always_ff @(posedge clk) begin
        if (rst || !csb_r[B_RX_ENABLE_BIT]) begin
            rx_st_r <= RX_IDLE;
            rsh_r <= 10'h000;
            rbit_r <= 4'h0;
            ros_r <= 5'h00;
        end else begin
            unique case (rx_st_r)
                RX_IDLE: begin
                    rbit_r <= 4'h0;
                    ros_r <= 5'h00;
                    if (sync_md && rx_edge && !rxd) begin
                        rx_st_r <= RX_DATA;
                    end else if (!sync_md && btick && !rxd) begin
                        rx_st_r <= RX_START;
                    end
                end
                RX_START: begin
                    // confirm start at middle of bit
                    if (btick) begin
                        ros_r <= ros_r + 5'd1;
                        if (ros_r == (osr >> 1) - 5'd1) begin
                            ros_r <= 5'h00;
                            rx_st_r <= rxd ? RX_IDLE : RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (btick) begin
                        ros_r <= (ros_r == osr - 5'd1) ? 5'h00 : ros_r + 5'd1;
                    end
                    if (rsamp) begin
                        rsh_r[rbit_r] <= rxd;
                        rbit_r <= rbit_r + 4'd1;
                        if (rdone) begin
                            rx_st_r <= RX_IDLE;
                        end
                    end
                end
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // receive buffer and complete flag, new frame wins over read
    always_ff @(posedge clk) begin
        if (rst || !csb_r[B_RX_ENABLE_BIT]) begin
            rbuf_r <= 9'h000;
            rxc_r <= 1'b0;
        end else if (rdone) begin
            rbuf_r <= rsh_r[8:0] & dmask;
            rxc_r <= 1'b1;
        end else if (rd_data) begin
            rxc_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // read port and interrupt requests
    // ----------------------------------------
    // registered read data, zero for unmapped
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (rd_stb) begin
            unique case (addr)
                ADR_DATA: rdata_r <= rbuf_r[7:0];
                ADR_CSA: begin
                    rdata_r <= 8'h00;
                    rdata_r[A_RXC] <= rxc_r;
                    rdata_r[A_TXC] <= txc_r;
                    rdata_r[A_TX_BUFFER_EMPTY_FLAG] <= !tfull_r;
                    rdata_r[A_U2X] <= u2x_r;
                end
                ADR_CSB: begin
                    rdata_r <= csb_r;
                    rdata_r[B_RX_NINTH_BIT] <= rbuf_r[8];
                end
                ADR_CSC: rdata_r <= csc_r;
                ADR_BRL: rdata_r <= baud_r[7:0];
                ADR_BRH: rdata_r <= {4'h0, baud_r[11:8]};
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign rdata = rdata_r;
    assign tx_empty_irq = csb_r[B_TX_EMPTY_IRQ_ENABLE] && !tfull_r;
    assign tx_complete_irq = csb_r[B_TX_COMPLETE_IRQ_ENABLE] && txc_r;
    assign rx_complete_irq = csb_r[B_RXCIE] && rxc_r;
endmodule

/* File: tb/usr_datapath_monitor.sv */
// checker: port-level properties of the serial data paths
module usr_datapath_mon (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rdata,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    input wire logic serial_in_pin,
    input wire logic serial_in_override,
    input wire logic serial_clock_pin,
    input wire logic serial_clock_override,
    input wire logic tx_empty_irq,
    input wire logic tx_complete_irq,
    input wire logic tx_complete_irq_ack,
    input wire logic rx_complete_irq
);
    timeunit 1ns;
    timeprecision 100ps;
    import usr_pkg::*;
    logic tx_complete_irq_enable_r; // shadow of complete irq enable
    logic tx_empty_irq_enable_r; // shadow of empty irq enable
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // --------------------------------
    // enable shadows
    // --------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_complete_irq_enable_r <= 1'b0;
            tx_empty_irq_enable_r <= 1'b0;
        end else if (wr_stb && addr == ADR_CSB) begin
            tx_complete_irq_enable_r <= wdata[B_TX_COMPLETE_IRQ_ENABLE];
            tx_empty_irq_enable_r <= wdata[B_TX_EMPTY_IRQ_ENABLE];
        end
    end
    sequence s_csb_wr;
        wr_stb && addr == ADR_CSB;
    endsequence
    sequence s_csa_wr;
        wr_stb && addr == ADR_CSA;
    endsequence
    // --------------------------------
    // properties
    // --------------------------------
    AST_RX_ON: assert property (s_csb_wr ##0 wdata[B_RX_ENABLE_BIT] |=> serial_in_override)
        else $error("receiver did not take the input pin");
    AST_RX_OFF: assert property (s_csb_wr ##0 !wdata[B_RX_ENABLE_BIT] |=> !serial_in_override)
        else $error("receiver kept the input pin");
    AST_TX_OWN: assert property (s_csb_wr ##0 wdata[B_TX_ENABLE_BIT] |=> serial_out_oe)
        else $error("transmitter did not take the output pin");
    AST_IDLE_HIGH: assert property (!serial_out_oe |-> serial_out_pin)
        else $error("released output not high");
    AST_START_OWNED: assert property ($fell(serial_out_pin) |-> serial_out_oe)
        else $error("frame started on a released pin");
    AST_NO_DROP: assert property (serial_out_oe && !serial_out_pin |=> serial_out_oe)
        else $error("pin released in mid frame");
    AST_EMPTY_CLR: assert property (wr_stb && addr == ADR_DATA |=> !tx_empty_irq)
        else $error("empty request after data write");
    AST_EMPTY_EN: assert property (tx_empty_irq |-> tx_empty_irq_enable_r)
        else $error("empty request while disabled");
    AST_TXC_EN: assert property ($rose(tx_complete_irq) |-> tx_complete_irq_enable_r)
        else $error("complete request while disabled");
    AST_TXC_ACK: assert property (tx_complete_irq_ack |=> !tx_complete_irq)
        else $error("complete flag kept after service");
    AST_TXC_W1C: assert property (s_csa_wr ##0 wdata[A_TXC] |=> !tx_complete_irq)
        else $error("complete flag kept after write one");
    AST_RXC_OWN: assert property (rx_complete_irq |-> serial_in_override)
        else $error("receive request with receiver off");
endmodule
bind usr_datapath usr_datapath_mon u_mon (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .serial_in_pin(serial_in_pin), .serial_in_override(serial_in_override), .serial_clock_pin(serial_clock_pin),
    .serial_clock_override(serial_clock_override), .tx_empty_irq(tx_empty_irq), .tx_complete_irq(tx_complete_irq),
    .tx_complete_irq_ack(tx_complete_irq_ack), .rx_complete_irq(rx_complete_irq));

/* File: tb/usr_remote.sv */
// partner: remote serial transceiver on the line side
module usr_remote (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int bt = 16; // cycles per bit
    int nbits = 8; // data bits per char
    bit par_en; // parity bit present
    bit par_odd; // odd parity
    logic [9:0] got_q[$]; // received chars, parity in bit 9
    initial line_out = 1'b1; // line idles high
    // --------------------------------
    // receiver: samples mid bit
    // --------------------------------
    always begin : rx_blk
        logic [9:0] v;
        @(negedge line_in);
        v = '0;
        repeat (bt / 2) @(posedge clk);
        for (int i = 0; i < nbits + par_en; i++) begin
            repeat (bt) @(posedge clk);
            if (i < nbits) v[i] = line_in; else v[9] = line_in;
        end
        repeat (bt) @(posedge clk); // first stop
        got_q.push_back(v);
    end
    // --------------------------------
    // sender: start, lsb first, parity, one stop
    // --------------------------------
    task automatic send(input logic [8:0] d);
        logic [8:0] m;
        m = d & 9'((1 << nbits) - 1);
        @(posedge clk) line_out <= 1'b0;
        for (int i = 0; i < nbits + par_en + 1; i++) begin
            repeat (bt) @(posedge clk);
            line_out <= (i < nbits) ? m[i] : (i == nbits && par_en) ? ^m ^ par_odd : 1'b1;
        end
        repeat (bt) @(posedge clk);
    endtask
endmodule

/* File: tb/tb_top.sv */
// testbench: register-level tests of the serial data paths against a remote model
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import usr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = '0;
    logic [7:0] wdata = '0;
    logic [7:0] rdata;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic ack = 1'b0; // complete irq serviced
    logic sck = 1'b0; // external serial clock, synchronous mode
    logic sclk_ov; // clock pin taken over
    logic [9:0] sv; // output bits seen at falling clock edges
    logic sout, soe, sin, sin_ov, e_irq, c_irq, r_irq;
    int errors = 0;
    int comparisons = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    usr_datapath u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .serial_out_pin(sout), .serial_out_oe(soe), .serial_in_pin(sin),
        .serial_in_override(sin_ov), .serial_clock_pin(sck), .serial_clock_override(sclk_ov),
        .tx_empty_irq(e_irq), .tx_complete_irq(c_irq), .tx_complete_irq_ack(ack), .rx_complete_irq(r_irq));
    usr_remote u_rem (.clk(clk), .line_in(sout), .line_out(sin));
    // --------------------------------
    // tasks
    // --------------------------------
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end
    // --------------------------------
    // tests
    // --------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(ADR_CSA, 8'h20);
        rd(ADR_CSB, RST_CSB);
        rd(ADR_CSC, RST_CSC);
        rd(3'h6, 8'h00);
        `CHK({soe, sout}, 2'b01)
        $display("test reset done");
        wr(ADR_CSB, 8'h68);
        `CHK({soe, sout, e_irq}, 3'b111)
        wr(ADR_DATA, 8'hA5);
        `CHK(e_irq, 1'b0)
        wr(ADR_DATA, 8'h3C);
        rd(ADR_CSA, 8'h00);
        wait (u_rem.got_q.size() == 2);
        `CHK(u_rem.got_q[0], 10'h0A5)
        `CHK(u_rem.got_q[1], 10'h03C)
        wait (c_irq === 1'b1);
        rd(ADR_CSA, 8'h60);
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        #1;
        `CHK(c_irq, 1'b0)
        u_rem.got_q.delete();
        $display("test transmit done");
        for (int i = 0; i < 2; i++) begin
            u_rem.nbits = 5;
            u_rem.par_en = 1'b1;
            u_rem.par_odd = i[0];
            u_rem.bt = i ? 8 : 16;
            wr(ADR_CSA, {6'h00, i[0], 1'b0});
            wr(ADR_CSC, {2'h0, 1'b1, i[0], 4'h0});
            wr(ADR_DATA, 8'hFF);
            wait (u_rem.got_q.size() == 1);
            `CHK(u_rem.got_q[0], {~i[0], 9'h01F})
            wait (c_irq === 1'b1);
            wr(ADR_CSA, 8'h40);
            `CHK(c_irq, 1'b0)
            u_rem.got_q.delete();
        end
        $display("test parity done");
        u_rem.nbits = 9;
        u_rem.par_en = 1'b0;
        u_rem.bt = 16;
        wr(ADR_CSC, 8'h06);
        wr(ADR_CSB, 8'h4D);
        wr(ADR_DATA, 8'h5A);
        wait (u_rem.got_q.size() == 1);
        `CHK(u_rem.got_q[0], 10'h15A)
        u_rem.got_q.delete();
        wr(ADR_CSB, 8'hD4);
        `CHK(sin_ov, 1'b1)
        u_rem.send(9'h1A5);
        wait (r_irq === 1'b1);
        rd(ADR_CSB, 8'hD6);
        rd(ADR_DATA, 8'hA5);
        wr(ADR_CSB, 8'h90);
        wr(ADR_CSC, 8'h08);
        u_rem.nbits = 5;
        fork
            begin
                u_rem.send(9'h1FF);
                u_rem.send(9'h00A);
            end
        join_none
        wait (r_irq === 1'b1);
        rd(ADR_DATA, 8'h1F);
        wait (r_irq === 1'b1);
        rd(ADR_DATA, 8'h0A);
        $display("test receive done");
        wr(ADR_CSB, 8'h08);
        wr(ADR_DATA, 8'h11);
        wr(ADR_CSB, 8'h00);
        `CHK({soe, sin_ov}, 2'b10)
        wait (soe === 1'b0);
        `CHK(u_rem.got_q.size(), 1)
        `CHK(u_rem.got_q[0], 10'h011)
        $display("test disable done");
        wr(ADR_CSC, 8'h46);
        wr(ADR_CSB, 8'h08);
        wr(ADR_DATA, 8'h96);
        `CHK({sclk_ov, sout}, 2'b11)
        for (int i = 0; i < 10; i++) begin
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            repeat (4) @(posedge clk);
            sck <= 1'b0;
            sv[i] = sout;
        end
        `CHK(sv, {1'b1, 8'h96, 1'b0})
        $display("test sync done");
        give_verdict();
    end
endmodule
